// *** shared/cpc_pkg.sv ***
// Constants, types and decoders shared by the command/address parity checker
`default_nettype none

package cpc_pkg;

  // ==========================================================================
  // Command word layout: {act_n, addr[17:0], bg[1:0], ba[1:0], cid[2:0], par}
  localparam int ADDR_W  = 18;
  localparam int BG_W    = 2;
  localparam int BA_W    = 2;
  localparam int CID_W   = 3;
  localparam int CMD_W   = 1 + ADDR_W + BG_W + BA_W + CID_W + 1;
  localparam int SYNC_W  = CMD_W + 2;            // Plus link clock and select
  localparam int A17_BIT = 17;

  // ==========================================================================
  // Latency field and delay line
  localparam int PLC_W = 3;
  localparam int PLN_W = 4;
  localparam int PTR_W = 3;
  localparam int DEPTH = 8;
  localparam logic [PLC_W-1:0] PLC_OFF = 3'h0;
  localparam logic [PLC_W-1:0] PLC_4   = 3'h1;
  localparam logic [PLC_W-1:0] PLC_5   = 3'h2;
  localparam logic [PLC_W-1:0] PLC_6   = 3'h3;
  localparam logic [PLC_W-1:0] PLC_8   = 3'h4;
  localparam logic [PLN_W-1:0] PLN_0   = 4'h0;
  localparam logic [PLN_W-1:0] PLN_4   = 4'h4;
  localparam logic [PLN_W-1:0] PLN_5   = 4'h5;
  localparam logic [PLN_W-1:0] PLN_6   = 4'h6;
  localparam logic [PLN_W-1:0] PLN_8   = 4'h8;

  // ==========================================================================
  // Timing, clock at 50 ns
  localparam int CLK_NS         = 50;
  localparam int ALERT_ON_NS    = 100;   // Longest, rounds down
  localparam int ALERT_PWMIN_NS = 2000;  // Least, rounds up
  localparam int ALERT_PWMAX_NS = 4000;  // Longest, rounds down
  localparam int TRAS_MIN_NS    = 1000;  // Least, rounds up
  localparam int ALERT_ON_CYC   = (ALERT_ON_NS / CLK_NS < 1) ? 1 : ALERT_ON_NS / CLK_NS;
  localparam int PW_MIN_CYC     = (ALERT_PWMIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int PW_MAX_CYC     = (ALERT_PWMAX_NS / CLK_NS < 1) ? 1 : ALERT_PWMAX_NS / CLK_NS;
  localparam int TRAS_CYC       = (TRAS_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W          = 12;
  localparam logic [CNT_W-1:0] PW_MIN_CNT = CNT_W'(PW_MIN_CYC);
  localparam logic [CNT_W-1:0] PW_MAX_CNT = CNT_W'(PW_MAX_CYC);
  localparam logic [CNT_W-1:0] TRAS_CNT   = CNT_W'(TRAS_CYC);
  localparam logic [CNT_W-1:0] CNT_MAX    = 12'hFFF;

  // Error recovery states
  typedef enum logic [1:0] {st_run, st_wait, st_hold} cpc_state_t;

  // Latency code to clock count, reserved codes disable
  function automatic logic [PLN_W-1:0] pl_cycles(input logic [PLC_W-1:0] code);
    case (code)
      PLC_4:   pl_cycles = PLN_4;
      PLC_5:   pl_cycles = PLN_5;
      PLC_6:   pl_cycles = PLN_6;
      PLC_8:   pl_cycles = PLN_8;
      default: pl_cycles = PLN_0;
    endcase
  endfunction : pl_cycles

endpackage : cpc_pkg

`default_nettype wire

// *** shared/cpc_mem_if.sv ***
// Interface between the checker and its delay line memory
`default_nettype none

interface cpc_mem_if;
  import cpc_pkg::*;
  logic                 we;
  logic [PTR_W-1:0]     waddr;
  logic [CMD_W-1:0]     wdata;
  logic [PTR_W-1:0]     raddr;
  logic [CMD_W-1:0]     rdata;

  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : cpc_mem_if

`default_nettype wire

// *** src/cpc_sync.sv ***
// Two-stage synchroniser for pins from the controller domain
`default_nettype none

module cpc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         rst_b_in,
  input  wire logic [W-1:0] d_in,
  output var  logic [W-1:0] q_out
);
  logic [W-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_q <= '0;
      q_out  <= '0;
    end else begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end
endmodule : cpc_sync

`default_nettype wire

// *** src/cpc_delay_mem.sv ***
// Command delay line memory with registered read data
`default_nettype none

module cpc_delay_mem (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  cpc_mem_if.mem    port
);
  import cpc_pkg::*;

  logic [CMD_W-1:0] mem_q [DEPTH];

  // Storage, no reset needed
  always_ff @(posedge clk_in) begin
    if (port.we) begin
      mem_q[port.waddr] <= port.wdata;
    end
  end

  // Registered read port
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      port.rdata <= '0;
    end else begin
      port.rdata <= mem_q[port.raddr];
    end
  end
endmodule : cpc_delay_mem

`default_nettype wire

// *** src/cpc_top.sv ***
// Command/address parity checker with latency delay line and alert sequencing
`default_nettype none

module cpc_top (
  input  wire logic                        clk_in,
  input  wire logic                        rst_b_in,
  input  wire logic                        ck_link_in,
  input  wire logic                        cs_n_in,
  input  wire logic                        act_n_in,
  input  wire logic [cpc_pkg::ADDR_W-1:0]  addr_in,
  input  wire logic [cpc_pkg::BG_W-1:0]    bg_in,
  input  wire logic [cpc_pkg::BA_W-1:0]    ba_in,
  input  wire logic [cpc_pkg::CID_W-1:0]   cid_in,
  input  wire logic                        par_in,
  input  wire logic [cpc_pkg::PLC_W-1:0]   parity_latency_in,
  input  wire logic                        dll_en_in,
  input  wire logic                        persist_en_in,
  input  wire logic                        crc_en_in,
  input  wire logic                        stack_used_in,
  input  wire logic                        a17_used_in,
  input  wire logic                        status_wr_in,
  input  wire logic                        status_wdata_in,
  output var  logic                        exec_valid_out,
  output var  logic [cpc_pkg::CMD_W-1:0]   exec_cmd_out,
  output var  logic                        alert_n_out,
  output var  logic                        status_out,
  output var  logic [cpc_pkg::CMD_W-1:0]   multipurpose_log_register_out,
  output var  logic                        crc_err_clr_out,
  output var  logic                        precharge_all_out,
  output var  logic [cpc_pkg::PLN_W-1:0]   parity_latency_eff_out
);
  import cpc_pkg::*;

  localparam int AON_MAX = ALERT_ON_CYC;

  // ==========================================================================
  // Pin synchronisation and link edge detection
  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] pins_syn;
  logic              ck_prev_q;
  logic              tick;
  logic              sel;
  logic [ADDR_W-1:0] addr_m;
  logic [CID_W-1:0]  cid_m;
  logic [CMD_W-1:0]  cmd_w;
  logic              parity_bad;

  assign pins_raw = {ck_link_in, cs_n_in, act_n_in, addr_in, bg_in, ba_in, cid_in, par_in};

  cpc_sync #(
    .W (SYNC_W)
  ) u_sync (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .d_in     (pins_raw),
    .q_out    (pins_syn)
  );

  // Previous link clock level
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ck_prev_q <= 1'b0;
    end else begin
      ck_prev_q <= pins_syn[SYNC_W-1];
    end
  end

  // Rising link edge with select low captures a command
  always_comb begin
    tick   = pins_syn[SYNC_W-1] & ~ck_prev_q;
    sel    = tick & ~pins_syn[SYNC_W-2];
    addr_m = pins_syn[CMD_W-2 -: ADDR_W];
    addr_m[A17_BIT] = addr_m[A17_BIT] & a17_used_in;
    cid_m  = pins_syn[CID_W:1] & {CID_W{stack_used_in}};
    cmd_w  = {pins_syn[CMD_W-1], addr_m, pins_syn[CID_W+BA_W+BG_W:CID_W+1], cid_m,
              pins_syn[0]};
    parity_bad = ^cmd_w;
  end

  // ==========================================================================
  // Delay line control
  cpc_mem_if mem_if ();

  cpc_delay_mem u_mem (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .port     (mem_if.mem)
  );

  cpc_state_t       state_q;
  cpc_state_t       state_d;
  logic [PLN_W-1:0] pl;
  logic             en;
  logic             check;
  logic             err_det;
  logic             accept;
  logic             push;
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] wr_ptr_d;
  logic [DEPTH-1:0] vld_q;
  logic [DEPTH-1:0] vld_d;
  logic             exec_valid_d;
  logic [CMD_W-1:0] exec_cmd_d;
  logic             status_q;
  logic             status_d;

  // Enable, check and accept decisions
  always_comb begin
    pl      = pl_cycles(parity_latency_in);
    en      = (pl != PLN_0) & dll_en_in;
    check   = en & (state_q == st_run) & (~status_q | persist_en_in);
    err_det = sel & check & parity_bad;
    accept  = sel & (state_q == st_run) & ~err_det;
    push    = accept & en;
    mem_if.we    = push;
    mem_if.waddr = wr_ptr_q;
    mem_if.wdata = cmd_w;
    mem_if.raddr = wr_ptr_q - pl[PTR_W-1:0];
  end

  // Next pointer, valid flags and execution strobe
  always_comb begin
    wr_ptr_d     = wr_ptr_q;
    vld_d        = vld_q;
    exec_valid_d = 1'b0;
    exec_cmd_d   = exec_cmd_out;
    if (tick && en) begin
      wr_ptr_d        = wr_ptr_q + 3'h1;
      vld_d[wr_ptr_q] = push;
      if (vld_q[mem_if.raddr] && state_q == st_run && !err_det) begin
        exec_valid_d = 1'b1;
        exec_cmd_d   = mem_if.rdata;
      end
    end else if (accept && !en) begin
      exec_valid_d = 1'b1;
      exec_cmd_d   = cmd_w;
    end
    if (err_det || !en) begin
      vld_d = '0;
    end
  end

  // Delay line registers
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_ptr_q       <= '0;
      vld_q          <= '0;
      exec_valid_out <= 1'b0;
      exec_cmd_out   <= '0;
    end else begin
      wr_ptr_q       <= wr_ptr_d;
      vld_q          <= vld_d;
      exec_valid_out <= exec_valid_d;
      exec_cmd_out   <= exec_cmd_d;
    end
  end

  // ==========================================================================
  // Error recovery sequence
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             pre_done_q;
  logic             pre_done_d;
  logic             alert_n_d;
  logic             pre_all_d;
  logic [CMD_W-1:0] log_d;
  logic             crc_clr_d;
  logic [PLN_W-1:0] lat_d;

  // Next state of alert, status and log
  always_comb begin
    state_d    = state_q;
    cnt_d      = (cnt_q == CNT_MAX) ? cnt_q : cnt_q + 12'h001;
    pre_done_d = pre_done_q;
    alert_n_d  = alert_n_out;
    pre_all_d  = 1'b0;
    log_d      = multipurpose_log_register_out;
    crc_clr_d  = err_det & crc_en_in;
    lat_d      = en ? pl : PLN_0;
    status_d   = status_q;
    if (status_wr_in && !status_wdata_in) begin
      status_d = 1'b0;
    end
    if (err_det) begin
      status_d = 1'b1;
      log_d    = cmd_w;
    end
    case (state_q)
      st_run: begin
        if (err_det) begin
          state_d    = st_wait;
          cnt_d      = '0;
          pre_done_d = 1'b0;
          alert_n_d  = 1'b0;
        end
      end
      st_wait: begin
        if (!pre_done_q && cnt_q >= TRAS_CNT) begin
          pre_all_d  = 1'b1;
          pre_done_d = 1'b1;
        end
        if (pre_done_q && cnt_q >= PW_MIN_CNT) begin
          alert_n_d = 1'b1;
          state_d   = (cnt_q >= PW_MAX_CNT) ? st_run : st_hold;
        end
      end
      st_hold: begin
        if (cnt_q >= PW_MAX_CNT) begin
          state_d = st_run;
        end
      end
      default: begin
        state_d = st_run;
      end
    endcase
  end

  // Recovery registers
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q                       <= st_run;
      cnt_q                         <= '0;
      pre_done_q                    <= 1'b0;
      alert_n_out                   <= 1'b1;
      precharge_all_out             <= 1'b0;
      status_q                      <= 1'b0;
      multipurpose_log_register_out <= '0;
      crc_err_clr_out               <= 1'b0;
      parity_latency_eff_out        <= '0;
    end else begin
      state_q                       <= state_d;
      cnt_q                         <= cnt_d;
      pre_done_q                    <= pre_done_d;
      alert_n_out                   <= alert_n_d;
      precharge_all_out             <= pre_all_d;
      status_q                      <= status_d;
      multipurpose_log_register_out <= log_d;
      crc_err_clr_out               <= crc_clr_d;
      parity_latency_eff_out        <= lat_d;
    end
  end

  assign status_out = status_q;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence s_err;
    err_det;
  endsequence

  sequence s_alert_lo;
    !alert_n_out;
  endsequence

  sequence s_release;
    $rose(alert_n_out);
  endsequence

  // Bad command while persistent checking runs
  sequence s_pers_bad;
    (state_q == st_run) && persist_en_in && en && sel && parity_bad;
  endsequence

  // Clean zero write to the status bit
  sequence s_clear;
    status_wr_in && !status_wdata_in && !err_det;
  endsequence

  alert_on_a: assert property (s_err |-> ##[1:AON_MAX] s_alert_lo)
    else $error("alert not asserted in time after parity error");
  status_set_a: assert property (s_err |=> status_q)
    else $error("status bit not set after parity error");
  rel_min_pulse_a: assert property (s_release |-> cnt_q > PW_MIN_CNT)
    else $error("alert released before minimum pulse width");
  rel_after_pre_a: assert property (s_release |-> pre_done_q && !precharge_all_out)
    else $error("alert released before banks precharged");
  drop_err_a: assert property (s_err |-> !mem_if.we ##1 !exec_valid_out)
    else $error("faulty command was queued or executed");
  log_capture_a: assert property (s_err |=> multipurpose_log_register_out == $past(cmd_w))
    else $error("error log does not hold faulty command");
  crc_clear_a: assert property (s_err ##0 crc_en_in |=> crc_err_clr_out)
    else $error("write CRC status not cleared on parity error");
  no_exec_alert_a: assert property (s_alert_lo |-> !exec_valid_out)
    else $error("command executed while alert active");
  odd_alerts_a: assert property (sel && check && parity_bad |=> s_alert_lo)
    else $error("odd parity did not raise alert");
  pers_check_a: assert property (s_pers_bad |=> s_alert_lo)
    else $error("persistent mode did not resume checking");

  // Status, precharge, strobe, CRC clear and latency guards
  exec_in_run_a: assert property (exec_valid_out |-> $past(state_q == st_run))
    else $error("command executed outside run state");
  status_clr_a: assert property (s_clear |=> !status_q)
    else $error("status bit not cleared by zero write");
  status_one_a: assert property (!status_q && !err_det |=> !status_q)
    else $error("status bit set without parity error");
  pre_in_wait_a: assert property (precharge_all_out |-> state_q == st_wait)
    else $error("precharge issued outside error recovery");
  crc_only_err_a: assert property (crc_err_clr_out |-> $past(err_det))
    else $error("write CRC clear without parity error");
  loop_off_a: assert property (!dll_en_in |=> parity_latency_eff_out == PLN_0)
    else $error("latency applied with delay loop off");

endmodule : cpc_top

`default_nettype wire

// *** verif/cpc_ctrl_model.sv ***
// Behavioural memory controller driving command clock, command word and parity
`default_nettype none

module cpc_ctrl_model (
  output var logic                       ck_link_out,
  output var logic                       cs_n_out,
  output var logic [cpc_pkg::CMD_W-2:0]  word_out,
  output var logic                       par_out,
  output var logic [15:0]                link_edges_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import cpc_pkg::*;

  // ==========================================================================
  // Free-running command clock, phase unrelated to the system clock
  initial begin
    ck_link_out = 1'b0;
    cs_n_out = 1'b1;
    word_out = 26'h0;
    par_out = 1'b1;
    link_edges_out = 16'h0;
    #37;
    forever begin
      #200;
      ck_link_out = ~ck_link_out;
      if (ck_link_out) link_edges_out = link_edges_out + 16'h1; // Count rising edges
    end
  end

  // ==========================================================================
  // One selected command; flip spoils parity on purpose
  task automatic send(input logic [CMD_W-2:0] w, input logic flip, output logic [15:0] edge_no);
    @(negedge ck_link_out);
    cs_n_out = 1'b0;
    word_out = w;
    par_out = ^w ^ flip;
    @(posedge ck_link_out);
    #1;
    edge_no = link_edges_out;
  endtask : send

  // Deselect; released lines show the inverse of their last value
  task automatic idle();
    @(negedge ck_link_out);
    cs_n_out = 1'b1;
    word_out = ~word_out;
    par_out = ~par_out;
  endtask : idle

endmodule : cpc_ctrl_model

`default_nettype wire

// *** verif/tb.sv ***
// Self-checking testbench for the command/address parity checker
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import cpc_pkg::*;

  logic             clk_in, rst_b_in, ck_link, cs_n, par, dll_en, persist_en, crc_en;
  logic             stack_used, a17_used, status_wr, status_wdata;
  logic             exec_valid, alert_n, status, crc_clr, pre_all;
  logic [CMD_W-2:0] cmd_w;
  logic [CMD_W-1:0] exec_cmd, log_word;
  logic [PLC_W-1:0] pl_code;
  logic [PLN_W-1:0] pl_eff;
  logic [15:0]      link_edges, e0;
  int               fail_count = 0;
  int               tests_run = 0;
  int               n_exec = 0;
  int               n_clr = 0;
  int               n_pre = 0;
  localparam logic [CMD_W-2:0] W1 = 26'h1234567;
  localparam logic [CMD_W-2:0] W2 = 26'h2C0FFEE;

  // ==========================================================================
  // Controller model and device
  cpc_ctrl_model i_ctrl (.ck_link_out(ck_link), .cs_n_out(cs_n), .word_out(cmd_w),
    .par_out(par), .link_edges_out(link_edges));

  cpc_top i_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .ck_link_in(ck_link), .cs_n_in(cs_n),
    .act_n_in(cmd_w[25]), .addr_in(cmd_w[24:7]), .bg_in(cmd_w[6:5]), .ba_in(cmd_w[4:3]),
    .cid_in(cmd_w[2:0]), .par_in(par), .parity_latency_in(pl_code), .dll_en_in(dll_en),
    .persist_en_in(persist_en), .crc_en_in(crc_en), .stack_used_in(stack_used),
    .a17_used_in(a17_used), .status_wr_in(status_wr), .status_wdata_in(status_wdata),
    .exec_valid_out(exec_valid), .exec_cmd_out(exec_cmd), .alert_n_out(alert_n),
    .status_out(status), .multipurpose_log_register_out(log_word), .crc_err_clr_out(crc_clr),
    .precharge_all_out(pre_all), .parity_latency_eff_out(pl_eff));

  // Clock at 50 ns
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  // Pulse counters, sampled away from the launching edge
  always @(negedge clk_in) begin
    if (exec_valid === 1'b1) n_exec++;
    if (crc_clr === 1'b1) n_clr++;
    if (pre_all === 1'b1) n_pre++;
  end

  // ==========================================================================
  // Shared helpers
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report

  function automatic logic [CMD_W-1:0] full(input logic [CMD_W-2:0] w, input logic flip);
    return {w, ^w ^ flip};
  endfunction : full

  task automatic wait_exec(input int n0);
    int k;
    k = 0;
    while (n_exec == n0 && k < 400) begin
      @(negedge clk_in);
      k++;
    end
    if (k >= 400) begin
      fail_count++;
      final_report();
    end
  endtask : wait_exec

  task automatic wait_alert(input logic lvl, output int c);
    c = 0;
    while (alert_n !== lvl && c < 400) begin
      @(negedge clk_in);
      c++;
    end
    if (c >= 400) begin
      fail_count++;
      final_report();
    end
  endtask : wait_alert

  task automatic recover();
    int c;
    wait_alert(1'b1, c);
    repeat (PW_MAX_CYC) @(negedge clk_in);
  endtask : recover

  // Latency changes always pass through off
  task automatic set_pl(input logic [PLC_W-1:0] code);
    @(negedge clk_in);
    pl_code = 3'h0;
    repeat (2) @(negedge clk_in);
    pl_code = code;
    repeat (2) @(negedge clk_in);
  endtask : set_pl

  task automatic write_status(input logic v);
    @(negedge clk_in);
    status_wr = 1'b1;
    status_wdata = v;
    @(negedge clk_in);
    status_wr = 1'b0;
    @(negedge clk_in);
  endtask : write_status

  task automatic run_cmd(input logic [CMD_W-2:0] w, input logic flip, input int n,
                         input logic [CMD_W-1:0] expw);
    int n0;
    n0 = n_exec;
    i_ctrl.send(w, flip, e0);
    i_ctrl.idle();
    wait_exec(n0);
    check("latency", link_edges - e0, n);
    check("command", exec_cmd, expw);
    repeat (2) @(negedge clk_in);
    check("exec count", n_exec - n0, 1);
  endtask : run_cmd

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    check("alert idle", alert_n, 1'b1);
    check("status reset", status, 1'b0);
    check("log reset", log_word, 27'h0);
    check("latency reset", pl_eff, 4'h0);
  endtask : t_reset

  // Every code, reserved ones included, then loop off
  task automatic t_latency();
    logic [PLN_W-1:0] tbl [8] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h8, 4'h0, 4'h0, 4'h0};
    for (int c = 0; c < 8; c++) begin
      set_pl(c[PLC_W-1:0]);
      check("latency field", pl_eff, tbl[c]);
      run_cmd(W1, tbl[c] == 4'h0, tbl[c], full(W1, tbl[c] == 4'h0));
    end
    @(negedge clk_in);
    dll_en = 1'b0;
    set_pl(3'h1);
    check("loop off latency", pl_eff, 4'h0);
    run_cmd(W2, 1'b1, 0, full(W2, 1'b1));
    dll_en = 1'b1;
    set_pl(3'h1);
  endtask : t_latency

  // Walking one over every covered bit
  task automatic t_walk();
    for (int i = 0; i < CMD_W - 1; i++) run_cmd(26'h1 << i, 1'b0, 4, full(26'h1 << i, 1'b0));
    check("walk no alert", alert_n, 1'b1);
  endtask : t_walk

  // Unused stack and A17 inputs count as zero
  task automatic t_unused();
    logic [CMD_W-2:0] w, m;
    w = W1 | 26'h1000005;
    m = w & 26'h2FFFFF8;
    @(negedge clk_in);
    stack_used = 1'b0;
    a17_used = 1'b0;
    run_cmd(w, ^(w ^ m), 4, full(m, 1'b0));
    check("unused no alert", alert_n, 1'b1);
    stack_used = 1'b1;
    a17_used = 1'b1;
  endtask : t_unused

  task automatic t_error(input logic persist);
    int c, x0, c0, p0;
    @(negedge clk_in);
    persist_en = persist;
    crc_en = ~persist;
    x0 = n_exec;
    c0 = n_clr;
    p0 = n_pre;
    i_ctrl.send(W2, 1'b0, e0);
    i_ctrl.send(W1, 1'b1, e0);
    i_ctrl.idle();
    repeat (3) @(negedge clk_in);
    check("alert on", alert_n, 1'b0);
    check("status set", status, 1'b1);
    check("log", log_word, full(W1, 1'b1));
    wait_alert(1'b1, c);
    check("alert width", c >= PW_MIN_CYC - 6, 1'b1);
    check("precharge", n_pre - p0, 1);
    check("dropped", n_exec - x0, 0);
    check("crc clear", n_clr - c0, persist ? 0 : 1);
    repeat (PW_MAX_CYC) @(negedge clk_in);
    check("status held", status, 1'b1);
    x0 = n_exec;
    i_ctrl.send(W2, 1'b1, e0);
    i_ctrl.idle();
    if (persist) begin
      repeat (3) @(negedge clk_in);
      check("persist alert", alert_n, 1'b0);
      recover();
    end else begin
      wait_exec(x0);
      check("unchecked run", exec_cmd, full(W2, 1'b1));
      check("no alert", alert_n, 1'b1);
      check("log kept", log_word, full(W1, 1'b1));
    end
    write_status(1'b0);
    check("status zero", status, 1'b0);
    write_status(1'b1);
    check("status one ignored", status, 1'b0);
    i_ctrl.send(W2, 1'b1, e0);
    i_ctrl.idle();
    repeat (3) @(negedge clk_in);
    check("resumed alert", alert_n, 1'b0);
    check("new log", log_word, full(W2, 1'b1));
    recover();
    write_status(1'b0);
    run_cmd(W1, 1'b0, 4, full(W1, 1'b0));
  endtask : t_error

  // ==========================================================================
  // Main sequence
  initial begin
    rst_b_in = 1'b0;
    pl_code = 3'h0;
    dll_en = 1'b1;
    persist_en = 1'b0;
    crc_en = 1'b0;
    stack_used = 1'b1;
    a17_used = 1'b1;
    status_wr = 1'b0;
    status_wdata = 1'b0;
    repeat (2) @(negedge clk_in);
    rst_b_in = 1'b1;
    repeat (2) @(negedge clk_in);
    t_reset();
    t_latency();
    t_walk();
    t_unused();
    t_error(1'b0);
    t_error(1'b1);
    final_report();
  end

endmodule : tb

`default_nettype wire
